// ---- rtl/rbs_pkg.sv ----
// package for the reset and brownout sequencer
// assumes one 100 MHz clock domain; all users reference names with rbs_pkg::
package rbs_pkg;

   // timing
   localparam int CLOCK_MHZ = 100;
   localparam int INSTR_CYCLE_NS = 500; // one instruction cycle, 20 MHz core
   localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [7:0] INSTR_CYCLE_CNT = 8'(INSTR_CYCLE_CLKS);

   // idle timer preset and width
   localparam logic [15:0] IDLE_PRESET = 16'h00f0;
   localparam logic [3:0] IDLE_PRESET_LOW_MASK = 4'hf;
   // clock monitor error release, in idle timer clocks (16 to 32)
   localparam logic [5:0] CLKMON_RELEASE = 6'h10;

   // reset values
   localparam logic [7:0] STACK_RESET = 8'h6f;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam int FAST_OSC_BIT = 6;
   localparam logic [7:0] IDLE_CTRL_RESET = 8'h40;
   localparam int TX_EMPTY_BIT = 0;
   localparam logic [7:0] SERIAL_CTRL_RESET = 8'h01;
   localparam logic [7:0] FLASH_TIMING_RESET = 8'h10; // value for 10 MHz input
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] WD_WINDOW_MAX = 16'hffff; // 64k idle clocks

   // sequencer states
   typedef enum logic [1:0] {
      RBS_RUN = 2'b00,
      RBS_HOLD = 2'b01,
      RBS_DELAY = 2'b10,
      RBS_COUNT = 2'b11
   } rbs_state_e;

   // reset values presented to the peripheral control registers
   typedef struct packed {
      logic [15:0] program_counter;
      logic [7:0] processor_status_word;
      logic [7:0] timer1_serial_control;
      logic [7:0] interrupt_control_reg;
      logic [7:0] timer_two_control;
      logic [7:0] timer_three_control;
      logic [7:0] high_speed_timer_control;
      logic [7:0] idle_timer_control;
      logic [7:0] wakeup_enable_reg;
      logic [7:0] wakeup_edge_select;
      logic [7:0] stack_pointer;
      logic [7:0] segment_ext;
      logic [7:0] serial_prescaler;
      logic [7:0] serial_control;
      logic [7:0] serial_receive_control;
      logic [7:0] serial_interrupt_control;
      logic [7:0] converter_control;
      logic [7:0] prog_address_low;
      logic [7:0] prog_address_high;
      logic [7:0] flash_program_timing;
      logic [15:0] watchdog_window;
      logic watchdog_armed;
      logic clock_monitor_armed;
      logic keep_pointers;
   } rbs_init_s;

   // state of the sequencer, all but the idle tick edge and the synchronisers
   typedef struct packed {
      rbs_state_e state;
      logic [15:0] idle_count;
      logic [7:0] pin_low_cnt;
      logic pin_reset;
      logic internal_reset;
      logic monitor_error;
      logic [5:0] monitor_cnt;
      logic powered;
   } rbs_regs_s;

endpackage

// ---- rtl/rbs_sequencer.sv ----
// reset and brownout sequencer: merges pin and brownout reset sources
// assumes supply detector levels and the pin arrive asynchronously
// assumes the core loads init_values while core_reset is high
//
// Contract
// - any reset clears timer two, timer three and fast timer controls
// - idle timer control clears except fast oscillator bit, set to one
// - wake-up enable and edge select cleared; pending left undefined
// - stack pointer loads 06f hex on reset
// - pointers kept on warm reset, undefined after power-on
// - data segment extension register cleared on reset
// - serial prescaler and controls cleared, transmit-buffer-empty set
// - converter control cleared; result registers left undefined
// - programming addresses cleared; flash timing preset for 10 MHz
// - watchdog leaves reset armed with maximum 64k service window; armed here only when watchdog_enable is high
// - watchdog and clock monitor inhibited while reset asserted
// - slow clock at reset end drives error pin low until 16 ticks
// - external reset pin assertion exits halt
// - brownout holds reset below threshold, idle timer preset 00fx
// - above threshold idle timer counts; underflow releases reset
// - brownout reset initializes everything like a pin reset
// - supply dip re-asserts reset, re-presets, restarts countdown
// - after deep drop reset held until power delay done
// - shallow dip skips the power delay
// - no further internal resets while supply stays above threshold
// - brownout disabled: no internal reset, pin must reset
// - program counter, status, timer1/serial, interrupt control cleared
`timescale 1ns/1ps
`default_nettype none

module rbs_sequencer (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // reset pin and supply detector
   input wire logic reset_pin_n,
   input wire logic brownout_enable,
   input wire logic supply_below,
   input wire logic deep_drop,
   input wire logic power_delay_done,
   // idle timer tick and clock monitor
   input wire logic idle_tick,
   input wire logic clock_too_slow,
   input wire logic watchdog_enable,
   // outputs
   output logic core_reset,
   output logic halt_exit,
   output logic checks_inhibit,
   output logic [15:0] idle_timer,
   output logic watchdog_error_pin,
   output logic watchdog_error_oe,
   output rbs_pkg::rbs_init_s init_values
);

   // ==========================================================
   // reset release and input synchronisers
   // arst_n is taken at once and let go two clocks later
   logic [1:0] rst_sync;
   logic srst_n;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rst_sync <= 2'b00;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign srst_n = rst_sync[1];

   // two stages for every asynchronous input
   // bit order: pin, below, deep, delay done, tick, slow
   // reset levels: pin released high, clock taken as slow until seen
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in, sync_a, sync_b;
   assign raw_in = {reset_pin_n, supply_below, deep_drop, power_delay_done,
                    idle_tick, clock_too_slow};
   always_ff @(posedge clock or negedge srst_n) begin
      if (!srst_n) begin
         sync_a <= 6'h21;
         sync_b <= 6'h21;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end
   logic pin_n_s, below_s, deep_s, delay_done_s, tick_s, slow_s;
   assign {pin_n_s, below_s, deep_s, delay_done_s, tick_s, slow_s} = sync_b;

   // ==========================================================
   // state registers
   // sequencer state in one struct; idle tick edge kept beside it
   rbs_pkg::rbs_regs_s r, next_r;
   logic tick_d;
   logic tick_rise;
   always_ff @(posedge clock or negedge srst_n) begin
      if (!srst_n) tick_d <= 1'b0;
      else tick_d <= tick_s;
   end
   assign tick_rise = tick_s & ~tick_d;

   // ==========================================================
   // sequencer next state
   // hold: supply low, timer preset; delay: waiting for power delay;
   // count: idle timer running down; run: reset released
   always_comb begin
      // default: every field keeps its value
      next_r = r;

      // pin qualifier: a low shorter than one instruction cycle is noise
      if (pin_n_s) begin
         // pin released, restart the low-time count
         next_r.pin_low_cnt = 8'h00;
         next_r.pin_reset = 1'b0;
      end else if (r.pin_low_cnt >= rbs_pkg::INSTR_CYCLE_CNT - 8'h01) begin
         // long enough: reset stands until the pin goes high
         next_r.pin_reset = 1'b1;
      end else begin
         // still counting the low time
         next_r.pin_low_cnt = r.pin_low_cnt + 8'h01;
      end

      // power record: cleared by a deep drop, set once the delay ends
      if (deep_s) begin
         next_r.powered = 1'b0;
      end else if (delay_done_s) begin
         next_r.powered = 1'b1;
      end

      // brownout sequence
      case (r.state)
         rbs_pkg::RBS_RUN: begin
            // no internal reset while above threshold
            if (brownout_enable && below_s) begin
               // supply dip: back into reset with the timer preset
               next_r.state = rbs_pkg::RBS_HOLD;
               next_r.internal_reset = 1'b1;
               next_r.idle_count = rbs_pkg::IDLE_PRESET;
            end else begin
               // normal running: idle timer counts on its own clock
               next_r.internal_reset = 1'b0;
               if (tick_rise) begin
                  next_r.idle_count = r.idle_count - 16'h0001;
               end
            end
         end
         rbs_pkg::RBS_HOLD: begin
            // supply below threshold: keep the preset loaded
            next_r.idle_count = rbs_pkg::IDLE_PRESET;
            if (!below_s) begin
               // deep drop needs the delay, shallow dip skips it
               if (r.powered && !deep_s) begin
                  next_r.state = rbs_pkg::RBS_COUNT;
               end else begin
                  next_r.state = rbs_pkg::RBS_DELAY;
               end
            end
         end
         rbs_pkg::RBS_DELAY: begin
            // supply good but power delay still running
            if (below_s) begin
               next_r.state = rbs_pkg::RBS_HOLD;
            end else if (delay_done_s && !deep_s) begin
               next_r.state = rbs_pkg::RBS_COUNT;
            end
         end
         rbs_pkg::RBS_COUNT: begin
            // countdown gated on supply and power delay
            if (below_s || !delay_done_s) begin
               next_r.state = rbs_pkg::RBS_HOLD;
               next_r.idle_count = rbs_pkg::IDLE_PRESET;
            end else if (tick_rise) begin
               // underflow out of zero ends the reset
               if (r.idle_count == 16'h0000) begin
                  next_r.state = rbs_pkg::RBS_RUN;
                  next_r.internal_reset = 1'b0;
               end
               next_r.idle_count = r.idle_count - 16'h0001;
            end
         end
         default: begin
            // unused code: fall back to a safe reset
            next_r.state = rbs_pkg::RBS_HOLD;
         end
      endcase

      // brownout off: never an internal reset, pin only
      if (!brownout_enable) begin
         next_r.state = rbs_pkg::RBS_RUN;
         next_r.internal_reset = 1'b0;
      end

      // clock monitor error after reset ends
      if (core_reset) begin
         // inhibited and cleared while reset stands
         next_r.monitor_error = 1'b0;
         next_r.monitor_cnt = 6'h00;
      end else if (slow_s) begin
         // clock too slow: error, and restart the good-clock count
         next_r.monitor_error = 1'b1;
         next_r.monitor_cnt = 6'h00;
      end else if (r.monitor_error && tick_rise) begin
         // clock good: count idle ticks before releasing the pin
         if (r.monitor_cnt == rbs_pkg::CLKMON_RELEASE - 6'h01) begin
            next_r.monitor_error = 1'b0;
         end else begin
            next_r.monitor_cnt = r.monitor_cnt + 6'h01;
         end
      end
   end

   // brownout comes out of power-up in reset
   // only constants here; the synchronised supply decides the rest
   always_ff @(posedge clock or negedge srst_n) begin
      if (!srst_n) begin
         r.state <= rbs_pkg::RBS_HOLD;
         r.idle_count <= rbs_pkg::IDLE_PRESET;
         r.pin_low_cnt <= 8'h00;
         r.pin_reset <= 1'b0;
         r.internal_reset <= 1'b1;
         r.monitor_error <= 1'b0;
         r.monitor_cnt <= 6'h00;
         r.powered <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // merged reset and pin outputs
   // brownout reset: the internal flag or any state short of run
   logic bo_reset;
   assign bo_reset = brownout_enable & (r.internal_reset |
                     (r.state != rbs_pkg::RBS_RUN));

   // one core reset for pin and brownout alike
   assign core_reset = r.pin_reset | bo_reset;

   // a qualified pin reset also wakes the core from halt
   assign halt_exit = r.pin_reset;

   // watchdog and monitor checks sleep while reset stands
   assign checks_inhibit = core_reset;

   // idle timer value, preset and counted by the sequencer
   assign idle_timer = r.idle_count;

   // error pin: low while the clock monitor error stands
   assign watchdog_error_pin = ~r.monitor_error;
   // pin is the watchdog output only when the watchdog is enabled
   assign watchdog_error_oe = watchdog_enable;

   // ==========================================================
   // reset values for the peripheral registers
   // all static except keep_pointers and the watchdog and clock monitor arming; the core loads them while core_reset is high
   always_comb begin
      // start from all zeros, then set each field by name
      init_values = '0;
      // core: program counter, status, timer1/serial, interrupts
      init_values.program_counter = rbs_pkg::PC_RESET;
      init_values.processor_status_word = rbs_pkg::ZERO_BYTE;
      init_values.timer1_serial_control = rbs_pkg::ZERO_BYTE;
      init_values.interrupt_control_reg = rbs_pkg::ZERO_BYTE;
      // timers two, three and the fast timer
      init_values.timer_two_control = rbs_pkg::ZERO_BYTE;
      init_values.timer_three_control = rbs_pkg::ZERO_BYTE;
      init_values.high_speed_timer_control = rbs_pkg::ZERO_BYTE;
      // idle timer control: only the fast oscillator bit set
      init_values.idle_timer_control = rbs_pkg::IDLE_CTRL_RESET;
      // wake-up enable and edge select; pending is not touched
      init_values.wakeup_enable_reg = rbs_pkg::ZERO_BYTE;
      init_values.wakeup_edge_select = rbs_pkg::ZERO_BYTE;
      // stack starts at the top of the lower base ram
      init_values.stack_pointer = rbs_pkg::STACK_RESET;
      // data segment extension back to segment zero
      init_values.segment_ext = rbs_pkg::ZERO_BYTE;
      // serial port: all clear but transmit buffer empty
      init_values.serial_prescaler = rbs_pkg::ZERO_BYTE;
      init_values.serial_control = rbs_pkg::SERIAL_CTRL_RESET;
      init_values.serial_receive_control = rbs_pkg::ZERO_BYTE;
      init_values.serial_interrupt_control = rbs_pkg::ZERO_BYTE;
      // converter control; result registers keep what they hold
      init_values.converter_control = rbs_pkg::ZERO_BYTE;
      // programming addresses and flash timing
      init_values.prog_address_low = rbs_pkg::ZERO_BYTE;
      init_values.prog_address_high = rbs_pkg::ZERO_BYTE;
      init_values.flash_program_timing = rbs_pkg::FLASH_TIMING_RESET;
      // watchdog: widest service window, armed only when enabled
      init_values.watchdog_window = rbs_pkg::WD_WINDOW_MAX;
      init_values.watchdog_armed = watchdog_enable;
      init_values.clock_monitor_armed = watchdog_enable;
      // pointers survive a warm reset only; after power-up they are junk
      init_values.keep_pointers = r.powered;
   end

endmodule // rbs_sequencer

`default_nettype wire

// ---- testbench/rbs_sequencer_asserts.sv ----
// checker for the reset and brownout sequencer, bound to its ports
// assumes one clock domain and async active-low arst_n
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // supply, pin and monitor inputs
   input wire logic reset_pin_n,
   input wire logic brownout_enable,
   input wire logic supply_below,
   input wire logic power_delay_done,
   input wire logic idle_tick,
   input wire logic clock_too_slow,
   input wire logic watchdog_enable,
   // outputs watched
   input wire logic core_reset,
   input wire logic halt_exit,
   input wire logic checks_inhibit,
   input wire logic [15:0] idle_timer,
   input wire logic watchdog_error_pin,
   input wire logic watchdog_error_oe,
   input wire rbs_pkg::rbs_init_s init_values
);
   logic [6:0] pin_lo;
   logic [5:0] ok_ticks;
   logic tick_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ================================================================
   // helpers: pin low length and idle ticks since clock became good
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_lo <= 7'h00;
         ok_ticks <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= idle_tick;
         pin_lo <= reset_pin_n ? 7'h00 : pin_lo + 7'(pin_lo != 7'h64);
         if (clock_too_slow)
            ok_ticks <= 6'h00;
         else if (idle_tick && !tick_q && ok_ticks != 6'h3f)
            ok_ticks <= ok_ticks + 6'h01;
      end
   end
   // ================================================================
   // assertions
   chk_inhibit_tracks: assert property (checks_inhibit == core_reset)
      else $error("checks inhibit differs from reset");
   chk_err_oe: assert property (watchdog_error_oe == watchdog_enable)
      else $error("error pin enable wrong");
   chk_preset_hold: assert property ((brownout_enable && supply_below)[*4]
      |-> core_reset && idle_timer == 16'h00f0)
      else $error("low supply did not hold preset reset");
   chk_delay_gate: assert property ((brownout_enable && !power_delay_done)[*4]
      |-> idle_timer == 16'h00f0)
      else $error("idle timer counted before power delay");
   chk_pin_reset: assert property (pin_lo == 7'd60
      |-> core_reset && halt_exit)
      else $error("long pin low gave no reset");
   chk_no_brownout: assert property ((!brownout_enable && reset_pin_n)[*8]
      |-> !core_reset)
      else $error("reset without brownout or pin");
   chk_stay_low: assert property ((reset_pin_n && !supply_below)[*4]
      ##0 !core_reset |=> !core_reset)
      else $error("spurious internal reset");
   chk_err_release: assert property (watchdog_enable && ok_ticks == 6'd40
      |-> watchdog_error_pin)
      else $error("error pin still low after good clock");
   chk_init_sp: assert property (core_reset
      |-> init_values.stack_pointer == 8'h6f)
      else $error("stack pointer reset value wrong");
   // main scenarios
   cov_release: cover property ($fell(core_reset));
   cov_err: cover property ($fell(watchdog_error_pin));
   cov_halt: cover property ($rose(halt_exit));
endmodule // rbs_sequencer_asserts
bind rbs_sequencer rbs_sequencer_asserts u_chk (.clock, .arst_n, .reset_pin_n,
   .brownout_enable, .supply_below, .power_delay_done, .idle_tick,
   .clock_too_slow, .watchdog_enable, .core_reset, .halt_exit,
   .checks_inhibit, .idle_timer, .watchdog_error_pin, .watchdog_error_oe,
   .init_values);
`default_nettype wire

// ---- testbench/rbs_supply_model.sv ----
// supply detector and idle timer clock source for the sequencer
// assumes level: 0 good, 1 below brownout, 2 below the deep trip
`timescale 1ns/1ps
`default_nettype none
module rbs_supply_model #(
   parameter int PDELAY = 400
) (
   // clock and supply level command
   input wire logic clock,
   input wire logic [1:0] level,
   // detector outputs
   output logic supply_below,
   output logic deep_drop,
   output logic power_delay_done,
   output logic idle_tick
);
   int dcnt = 0;
   logic [2:0] div = 3'h0;
   // ================================================================
   // comparator levels and delay flag
   assign supply_below = (level != 2'd0);
   assign deep_drop = (level == 2'd2);
   assign power_delay_done = (dcnt >= PDELAY);
   assign idle_tick = div[2];
   // delay restarts at every deep drop; idle clock runs free
   always_ff @(posedge clock) begin
      div <= div + 3'h1;
      if (level == 2'd2)
         dcnt <= 0;
      else if (dcnt < PDELAY)
         dcnt <= dcnt + 1;
   end
endmodule // rbs_supply_model
`default_nettype wire

// ---- testbench/tb_rbs_sequencer.sv ----
// testbench for the reset and brownout sequencer
// assumes the supply model file and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_rbs_sequencer;
   logic clock = 1'b0, arst_n = 1'b0, reset_pin_n = 1'b1, bo_en = 1'b1;
   logic slow = 1'b0, wd_en = 1'b1;
   logic [1:0] cmd = 2'd2;
   wire logic sb, dd, pdd, tick, core_reset, halt_exit, inh, err_pin, err_oe;
   wire logic [15:0] idle_timer;
   wire rbs_pkg::rbs_init_s iv;
   int err_total = 0, tests_run = 0;
   always #5 clock = ~clock;
   rbs_supply_model sup (.clock(clock), .level(cmd), .supply_below(sb),
      .deep_drop(dd), .power_delay_done(pdd), .idle_tick(tick));
   rbs_sequencer dut (.clock(clock), .arst_n(arst_n), .reset_pin_n(reset_pin_n),
      .brownout_enable(bo_en), .supply_below(sb), .deep_drop(dd),
      .power_delay_done(pdd), .idle_tick(tick), .clock_too_slow(slow),
      .watchdog_enable(wd_en), .core_reset(core_reset), .halt_exit(halt_exit),
      .checks_inhibit(inh), .idle_timer(idle_timer),
      .watchdog_error_pin(err_pin), .watchdog_error_oe(err_oe),
      .init_values(iv));
   // ================================================================
   // compare, wait and closing tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_rel(input int lo, input int hi);
      int n = 0;
      while (core_reset !== 1'b0 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      chk({15'h0, n > lo && n < hi}, 16'h0001);
   endtask
   task automatic wait_n(input int k);
      repeat (k) @(negedge clock);
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ================================================================
   // scenarios
   initial begin
      wait_n(8);
      chk(idle_timer, 16'h00f0);
      arst_n = 1'b1;
      cmd = 2'd1;
      wait_n(100);
      chk({iv.timer_two_control, iv.timer_three_control}, 16'h0000);
      chk({iv.high_speed_timer_control, iv.idle_timer_control}, 16'h0040);
      chk({iv.wakeup_enable_reg, iv.wakeup_edge_select}, 16'h0000);
      chk({iv.stack_pointer, iv.segment_ext}, 16'h6f00);
      chk({iv.serial_prescaler, iv.serial_control}, 16'h0001);
      chk({iv.serial_receive_control, iv.serial_interrupt_control}, 16'h0);
      chk({iv.converter_control, iv.prog_address_low}, 16'h0000);
      chk({iv.prog_address_high, iv.flash_program_timing}, 16'h0010);
      chk(iv.watchdog_window, 16'hffff);
      chk({14'h0, iv.watchdog_armed, iv.clock_monitor_armed}, 16'h0003);
      chk(iv.program_counter, 16'h0000);
      chk({iv.processor_status_word, iv.interrupt_control_reg}, 16'h0);
      chk({8'h0, iv.timer1_serial_control}, 16'h0000);
      cmd = 2'd0;
      wait_rel(2150, 2450);
      cmd = 2'd1;
      wait_n(50);
      chk(idle_timer, 16'h00f0);
      chk({14'h0, core_reset, inh}, 16'h0003);
      cmd = 2'd0;
      wait_rel(1880, 2090);
      wait_n(300);
      reset_pin_n = 1'b0;
      wait_n(30);
      reset_pin_n = 1'b1;
      wait_n(20);
      chk({15'h0, core_reset}, 16'h0000);
      slow = 1'b1;
      reset_pin_n = 1'b0;
      wait_n(80);
      chk({13'h0, core_reset, halt_exit, inh}, 16'h0007);
      chk({15'h0, iv.keep_pointers}, 16'h0001);
      chk({8'h0, iv.stack_pointer}, 16'h006f);
      reset_pin_n = 1'b1;
      wait_n(10);
      chk({13'h0, core_reset, err_pin, err_oe}, 16'h0001);
      slow = 1'b0;
      wait_n(80);
      chk({15'h0, err_pin}, 16'h0000);
      wait_n(300);
      chk({15'h0, err_pin}, 16'h0001);
      bo_en = 1'b0;
      arst_n = 1'b0;
      wait_n(4);
      arst_n = 1'b1;
      cmd = 2'd1;
      wait_n(50);
      chk({15'h0, core_reset}, 16'h0000);
      end_sim();
   end
   // hang guard
   initial begin
      #300000;
      err_total++;
      end_sim();
   end
endmodule // tb_rbs_sequencer
`default_nettype wire
